// >>> include/crq_pkg.sv
/*
 * Constants for the classifier range checker and QoS map block: register
 * offsets, range types, map keys and field layouts.
 * Assumes a 32-bit register port with byte addresses, one register a word.
 */
package crq_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] GRNG_TYPE_BASE = 16'h0000; // global type, word n
  localparam logic [15:0] GRNG_BND_BASE = 16'h0040; // global {end,start}
  localparam logic [15:0] PRNG_BASE = 16'h0100; // per-port block
  localparam logic [15:0] PRNG_STRIDE = 16'h0040; // bytes per port
  localparam logic [15:0] PRNG_BND_OFS = 16'h0020; // bounds inside port block
  localparam logic [15:0] MAPCFG_BASE = 16'h1000; // {key,base row}, 2 per port
  localparam logic [15:0] MAPCFG_STRIDE = 16'h0008;
  localparam logic [15:0] SETCTL_BASE = 16'h2000; // row enables
  localparam logic [15:0] ENTRY_BASE = 16'h8000; // map entries
  localparam logic [15:0] STATUS_ADDR = 16'hc000; // last vector and g_idx
  // ----------------------------------------------------------------
  // range checker types; zero leaves the checker unconfigured
  // ----------------------------------------------------------------
  localparam logic [3:0] RT_NONE = 4'h0;
  localparam logic [3:0] RT_DPORT = 4'h1;
  localparam logic [3:0] RT_SPORT = 4'h2;
  localparam logic [3:0] RT_SDPORT = 4'h3;
  localparam logic [3:0] RT_VID = 4'h4;
  localparam logic [3:0] RT_DSCP = 4'h5;
  localparam logic [3:0] RT_ETYPE = 4'h6;
  localparam logic [3:0] RT_OVID = 4'h7;
  localparam logic [3:0] RT_IVID = 4'h8;
  // ----------------------------------------------------------------
  // qos map keys
  // ----------------------------------------------------------------
  localparam logic [3:0] MK_NONE = 4'h0;
  localparam logic [3:0] MK_PCP = 4'h1;
  localparam logic [3:0] MK_DP_OUTER = 4'h2;
  localparam logic [3:0] MK_DP_MIDDLE = 4'h3;
  localparam logic [3:0] MK_DP_INNER = 4'h4;
  localparam logic [3:0] MK_DSCP_IP = 4'h5;
  localparam logic [3:0] MK_DSCP_ALL = 4'h6;
  localparam logic [3:0] MK_TC = 4'h7;
  localparam logic [3:0] MK_ETAG = 4'h8;
  localparam logic [9:0] NONIP_ROW_OFS = 10'h008; // dscp-all, non-ip rows
  // ----------------------------------------------------------------
  // cascade index control
  // ----------------------------------------------------------------
  localparam logic [1:0] NX_CLEAR = 2'h0;
  localparam logic [1:0] NX_LOAD = 2'h1;
  localparam logic [1:0] NX_KEEP = 2'h2;
  localparam logic [1:0] NX_ADD = 2'h3;
  localparam logic [2:0] LAST_LOOKUP = 3'h5; // six lookups, 0..5
  // ----------------------------------------------------------------
  // qos value vector {cos_id,dei,pcp,qos,dp,dscp,tc}, 21 bits
  // ----------------------------------------------------------------
  localparam int QV_W = 21;
  localparam int EN_W = 7;
  localparam int BND_W = 16; // start in [15:0], end in [31:16]
  localparam int MAPCFG_W = 13; // key in [12:9], base row in [8:0]
  localparam int GIDX_W = 12;
endpackage

// >>> rtl/crq_range_qos_map.sv
/*
 * Range checkers, cascade index and dual qos map lookup of the frame
 * classifier, with a plain register port for configuration.
 * Assumes frame fields arrive in one cycle with frm_vld_i, synchronous to
 * clk_i; results appear one cycle later.
 */
// What this block does
// - eight global and eight per-port range checkers, compared for every frame
// - global n and port n fold into one flag at vector bit n
// - a configured port checker overrides the global checker at its index
// - port-number types use tcp/udp ports, only for tcp/udp frames
// - combined port type matches when source or destination port lies in range
// - vid type uses the classified vid for every frame
// - dscp type uses classified dscp, only for ip frames
// - ethertype type uses frame ethertype for all frames
// - outer vid needs one tag, inner vid needs two tags
// - match when start <= value <= end, both inclusive
// - six cascaded lookups bound through a generic index
// - next generic index computed from previous action control and value
// - shared map table of 512 rows by eight entries
// - two map lookups per frame with their own keys
// - base row and key per port, overridable for one lookup
// - pcp key: outer or port pcp, row base, entry pcp
// - dei/pcp key from chosen tag, v = 8*dei+pcp, sixteen entries
// - ip dscp key: row base+dscp/8, non-ip gets no mapping
// - all-frames dscp: non-ip uses dei/pcp at row base+8+v/8
// - tc key: classified mpls tc, row base, entry tc
// - e-tag key from e-dei/e-pcp, no mapping without e-tag
// - entry values replace current ones only where row enable is set
`timescale 1ns/10ps
module crq_range_qos_map #(
  parameter int NPORT = 4,
  parameter int NRNG = 8,
  parameter int NROW = 512
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // frame request
  input wire logic frm_vld_i,
  input wire logic [$clog2(NPORT)-1:0] frm_port_i,
  input wire logic frm_tcpudp_i,
  input wire logic frm_ip_i,
  input wire logic [15:0] frm_sport_i,
  input wire logic [15:0] frm_dport_i,
  input wire logic [15:0] frm_etype_i,
  input wire logic [1:0] frm_ntags_i,
  input wire logic [11:0] frm_ovid_i,
  input wire logic [11:0] frm_ivid_i,
  input wire logic [2:0] frm_o_pcp_i,
  input wire logic frm_o_dei_i,
  input wire logic [2:0] frm_m_pcp_i,
  input wire logic frm_m_dei_i,
  input wire logic [2:0] frm_i_pcp_i,
  input wire logic frm_i_dei_i,
  input wire logic [2:0] port_pcp_i,
  input wire logic port_dei_i,
  input wire logic frm_etag_i,
  input wire logic [2:0] frm_e_pcp_i,
  input wire logic frm_e_dei_i,
  input wire logic [2:0] frm_mpls_tc_i,
  input wire logic [11:0] cl_vid_i,
  input wire logic [5:0] frm_dscp_i,
  input wire logic [crq_pkg::QV_W-1:0] cur_qos_i,
  input wire logic map_ovr_vld_i,
  input wire logic map_ovr_sel_i,
  input wire logic [3:0] map_ovr_key_i,
  input wire logic [8:0] map_ovr_base_i,
  // cascade
  input wire logic clm_vld_i,
  input wire logic [2:0] clm_lookup_i,
  input wire logic [1:0] clm_nxt_ctrl_i,
  input wire logic [crq_pkg::GIDX_W-1:0] clm_nxt_idx_i,
  // results
  output logic res_vld_o,
  output logic [NRNG-1:0] range_match_vector_o,
  output logic [crq_pkg::QV_W-1:0] new_qos_o,
  output logic [crq_pkg::GIDX_W-1:0] g_idx_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NRNG-1:0][3:0] g_type;
    logic [NRNG-1:0][31:0] g_bnd;
    logic [NPORT-1:0][NRNG-1:0][3:0] p_type;
    logic [NPORT-1:0][NRNG-1:0][31:0] p_bnd;
    logic [NPORT-1:0][1:0][crq_pkg::MAPCFG_W-1:0] map_cfg;
    logic [NROW-1:0][crq_pkg::EN_W-1:0] set_ctl;
    logic [NROW*8-1:0][crq_pkg::QV_W-1:0] ent;
    logic res_vld;
    logic [NRNG-1:0] vec;
    logic [crq_pkg::QV_W-1:0] qos;
    logic [crq_pkg::GIDX_W-1:0] g_idx;
    logic [31:0] rdata;
  } crq_state_s;

  crq_state_s st_r;
  crq_state_s st_nxt;
  logic [NRNG-1:0] g_hit;
  logic [NRNG-1:0] p_hit;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // inclusive bounds check, shared by both checker sets
  function automatic logic in_rng(input logic [15:0] v, input logic [31:0] b);
    in_rng = (v >= b[15:0]) && (v <= b[31:16]);
  endfunction

  // one range checker; inapplicable types answer no match
  function automatic logic rng_hit(input logic [3:0] t, input logic [31:0] b);
    logic h;
    h = 1'b0;
    case (t)
      crq_pkg::RT_DPORT: h = frm_tcpudp_i && in_rng(frm_dport_i, b);
      crq_pkg::RT_SPORT: h = frm_tcpudp_i && in_rng(frm_sport_i, b);
      crq_pkg::RT_SDPORT: h = frm_tcpudp_i && (in_rng(frm_sport_i, b) || in_rng(frm_dport_i, b));
      crq_pkg::RT_VID: h = in_rng({4'h0, cl_vid_i}, b);
      crq_pkg::RT_DSCP: h = frm_ip_i && in_rng({10'h000, frm_dscp_i}, b);
      crq_pkg::RT_ETYPE: h = in_rng(frm_etype_i, b);
      crq_pkg::RT_OVID: h = (frm_ntags_i != 2'h0) && in_rng({4'h0, frm_ovid_i}, b);
      crq_pkg::RT_IVID: h = (frm_ntags_i >= 2'h2) && in_rng({4'h0, frm_ivid_i}, b);
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  // map key to {valid, row, entry}; row may exceed the table, checked later
  function automatic logic [13:0] map_pos(input logic [crq_pkg::MAPCFG_W-1:0] cfg);
    logic [3:0] key;
    logic [9:0] base;
    logic [3:0] v;
    logic ok;
    logic [9:0] row;
    logic [2:0] ent;
    key = cfg[12:9];
    base = {1'b0, cfg[8:0]};
    v = (frm_ntags_i == 2'h0) ? {port_dei_i, port_pcp_i} : {frm_o_dei_i, frm_o_pcp_i};
    ok = 1'b1;
    row = base;
    ent = 3'h0;
    case (key)
      crq_pkg::MK_PCP: ent = v[2:0];
      crq_pkg::MK_DP_OUTER, crq_pkg::MK_DP_MIDDLE, crq_pkg::MK_DP_INNER: begin
        // a missing selected tag falls back to the port tag
        if (key == crq_pkg::MK_DP_MIDDLE && frm_ntags_i >= 2'h2) begin
          v = {frm_m_dei_i, frm_m_pcp_i};
        end else if (key == crq_pkg::MK_DP_INNER && frm_ntags_i == 2'h3) begin
          v = {frm_i_dei_i, frm_i_pcp_i};
        end else if (key != crq_pkg::MK_DP_OUTER) begin
          v = {port_dei_i, port_pcp_i};
        end
        row = base + {9'h000, v[3]};
        ent = v[2:0];
      end
      crq_pkg::MK_DSCP_IP, crq_pkg::MK_DSCP_ALL: begin
        if (frm_ip_i) begin
          row = base + {7'h00, frm_dscp_i[5:3]};
          ent = frm_dscp_i[2:0];
        end else if (key == crq_pkg::MK_DSCP_ALL) begin
          row = base + crq_pkg::NONIP_ROW_OFS + {9'h000, v[3]};
          ent = v[2:0];
        end else begin
          ok = 1'b0;
        end
      end
      crq_pkg::MK_TC: ent = frm_mpls_tc_i;
      crq_pkg::MK_ETAG: begin
        ok = frm_etag_i;
        row = base + {9'h000, frm_e_dei_i};
        ent = frm_e_pcp_i;
      end
      default: ok = 1'b0;
    endcase
    return {ok, row, ent};
  endfunction

  // ----------------------------------------------------------------
  // range checkers
  // ----------------------------------------------------------------
  // each index folds its global and per-port checker into one bit
  for (genvar n = 0; n < NRNG; n++) begin : g_rng
    // a process, not an assign: the checker reads frame fields that are not
    // its arguments, and an assign would only wake on its arguments
    always_comb begin
      g_hit[n] = rng_hit(st_r.g_type[n], st_r.g_bnd[n]);
      p_hit[n] = rng_hit(st_r.p_type[frm_port_i][n], st_r.p_bnd[frm_port_i][n]);
    end
  end

  // ----------------------------------------------------------------
  // next state: registers, frame results, cascade
  // ----------------------------------------------------------------
  always_comb begin
    logic [NRNG-1:0] vec;
    logic [1:0][crq_pkg::MAPCFG_W-1:0] cfg;
    logic [13:0] pos;
    logic [9:0] row;
    logic [crq_pkg::QV_W-1:0] q;
    logic [crq_pkg::QV_W-1:0] m;
    logic [crq_pkg::EN_W-1:0] en;
    logic [15:0] a;
    logic [15:0] k;
    vec = '0;
    cfg = '0;
    pos = '0;
    row = '0;
    q = cur_qos_i;
    m = '0;
    en = '0;
    a = reg_addr_i;
    k = '0;
    st_nxt = st_r;
    st_nxt.res_vld = frm_vld_i;
    st_nxt.rdata = '0;
    // port checker wins whenever it is configured
    for (int n = 0; n < NRNG; n++) begin
      vec[n] = (st_r.p_type[frm_port_i][n] != crq_pkg::RT_NONE) ? p_hit[n] : g_hit[n];
    end
    // two lookups; a classifier override redefines one of them
    cfg = st_r.map_cfg[frm_port_i];
    if (map_ovr_vld_i) begin
      cfg[map_ovr_sel_i] = {map_ovr_key_i, map_ovr_base_i};
    end
    for (int l = 0; l < 2; l++) begin
      pos = map_pos(cfg[l]);
      row = pos[12:3];
      if (pos[13] && row < 10'(NROW)) begin
        en = st_r.set_ctl[row[8:0]];
        m = {{3{en[6]}}, en[5], {3{en[4]}}, {3{en[3]}}, {2{en[2]}}, {6{en[1]}}, {3{en[0]}}};
        q = (st_r.ent[{row[8:0], pos[2:0]}] & m) | (q & ~m);
      end
    end
    if (frm_vld_i) begin
      st_nxt.vec = vec;
      st_nxt.qos = q;
    end
    // cascade: index for the next lookup, none after the last
    if (clm_vld_i) begin
      if (clm_lookup_i >= crq_pkg::LAST_LOOKUP) begin
        st_nxt.g_idx = '0;
      end else begin
        case (clm_nxt_ctrl_i)
          crq_pkg::NX_LOAD: st_nxt.g_idx = clm_nxt_idx_i;
          crq_pkg::NX_KEEP: st_nxt.g_idx = st_r.g_idx;
          crq_pkg::NX_ADD: st_nxt.g_idx = st_r.g_idx + clm_nxt_idx_i;
          default: st_nxt.g_idx = '0;
        endcase
      end
    end
    // register writes
    if (reg_wr_i) begin
      if (a >= crq_pkg::ENTRY_BASE && a < crq_pkg::STATUS_ADDR) begin
        k = (a - crq_pkg::ENTRY_BASE) >> 2;
        if (k < 16'(NROW * 8)) st_nxt.ent[k] = reg_wdata_i[crq_pkg::QV_W-1:0];
      end else if (a >= crq_pkg::SETCTL_BASE && a < crq_pkg::ENTRY_BASE) begin
        k = (a - crq_pkg::SETCTL_BASE) >> 2;
        if (k < 16'(NROW)) st_nxt.set_ctl[k] = reg_wdata_i[crq_pkg::EN_W-1:0];
      end else if (a >= crq_pkg::MAPCFG_BASE && a < crq_pkg::SETCTL_BASE) begin
        k = (a - crq_pkg::MAPCFG_BASE) >> 2;
        if (k < 16'(NPORT * 2)) st_nxt.map_cfg[k >> 1][k[0]] = reg_wdata_i[crq_pkg::MAPCFG_W-1:0];
      end else if (a >= crq_pkg::PRNG_BASE && a < crq_pkg::MAPCFG_BASE) begin
        k = (a - crq_pkg::PRNG_BASE) / crq_pkg::PRNG_STRIDE;
        if (k < 16'(NPORT)) begin
          if (a[5:0] < crq_pkg::PRNG_BND_OFS[5:0]) st_nxt.p_type[k][a[4:2]] = reg_wdata_i[3:0];
          else st_nxt.p_bnd[k][a[4:2]] = reg_wdata_i;
        end
      end else if (a >= crq_pkg::GRNG_BND_BASE && a < crq_pkg::GRNG_BND_BASE + 16'(NRNG * 4)) begin
        st_nxt.g_bnd[a[4:2]] = reg_wdata_i;
      end else if (a < crq_pkg::GRNG_TYPE_BASE + 16'(NRNG * 4)) begin
        st_nxt.g_type[a[4:2]] = reg_wdata_i[3:0];
      end
    end
    // register reads; unmapped words read zero
    if (reg_rd_i) begin
      if (a >= crq_pkg::STATUS_ADDR) begin
        if (a == crq_pkg::STATUS_ADDR) st_nxt.rdata = {4'h0, st_r.g_idx, 8'h00, 8'(st_r.vec)};
      end else if (a >= crq_pkg::ENTRY_BASE) begin
        k = (a - crq_pkg::ENTRY_BASE) >> 2;
        if (k < 16'(NROW * 8)) st_nxt.rdata = 32'(st_r.ent[k]);
      end else if (a >= crq_pkg::SETCTL_BASE) begin
        k = (a - crq_pkg::SETCTL_BASE) >> 2;
        if (k < 16'(NROW)) st_nxt.rdata = 32'(st_r.set_ctl[k]);
      end else if (a >= crq_pkg::MAPCFG_BASE) begin
        k = (a - crq_pkg::MAPCFG_BASE) >> 2;
        if (k < 16'(NPORT * 2)) st_nxt.rdata = 32'(st_r.map_cfg[k >> 1][k[0]]);
      end else if (a >= crq_pkg::PRNG_BASE) begin
        k = (a - crq_pkg::PRNG_BASE) / crq_pkg::PRNG_STRIDE;
        if (k < 16'(NPORT)) begin
          if (a[5:0] < crq_pkg::PRNG_BND_OFS[5:0]) st_nxt.rdata = 32'(st_r.p_type[k][a[4:2]]);
          else st_nxt.rdata = st_r.p_bnd[k][a[4:2]];
        end
      end else if (a >= crq_pkg::GRNG_BND_BASE && a < crq_pkg::GRNG_BND_BASE + 16'(NRNG * 4)) begin
        st_nxt.rdata = st_r.g_bnd[a[4:2]];
      end else if (a < crq_pkg::GRNG_TYPE_BASE + 16'(NRNG * 4)) begin
        st_nxt.rdata = 32'(st_r.g_type[a[4:2]]);
      end
    end
  end

  // ----------------------------------------------------------------
  // state register; the table clears on reset so stale maps never leak
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign res_vld_o = st_r.res_vld;
  assign range_match_vector_o = st_r.vec;
  assign new_qos_o = st_r.qos;
  assign g_idx_o = st_r.g_idx;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RES_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i |=> res_vld_o)
    else $error("result valid missing one cycle after request");
  AST_PORT_TYPE_NONTCP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i && !frm_tcpudp_i && st_r.p_type[frm_port_i][0] == crq_pkg::RT_NONE
    && st_r.g_type[0] == crq_pkg::RT_DPORT |=> !range_match_vector_o[0])
    else $error("port range matched a non tcp/udp frame");
  AST_VID_START_INCL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i && st_r.p_type[frm_port_i][3] == crq_pkg::RT_NONE && st_r.g_type[3] == crq_pkg::RT_VID
    && {4'h0, cl_vid_i} == st_r.g_bnd[3][15:0] && st_r.g_bnd[3][31:16] >= st_r.g_bnd[3][15:0]
    |=> range_match_vector_o[3])
    else $error("range start point not inclusive");
  AST_PORT_OVERRIDES: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i && st_r.p_type[frm_port_i][0] != crq_pkg::RT_NONE && !p_hit[0] && g_hit[0]
    |=> !range_match_vector_o[0])
    else $error("global checker won over configured port checker");
  AST_IVID_TWO_TAGS: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i && frm_ntags_i < 2'h2 && st_r.g_type[7] == crq_pkg::RT_IVID
    && st_r.p_type[frm_port_i][7] == crq_pkg::RT_NONE |=> !range_match_vector_o[7])
    else $error("inner vid range matched with fewer than two tags");
  AST_NONIP_NO_MAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i && !frm_ip_i && !map_ovr_vld_i && st_r.map_cfg[frm_port_i][0][12:9] == crq_pkg::MK_DSCP_IP
    && (st_r.map_cfg[frm_port_i][1][12:9] == crq_pkg::MK_DSCP_IP
    || st_r.map_cfg[frm_port_i][1][12:9] == crq_pkg::MK_NONE) |=> new_qos_o == $past(cur_qos_i))
    else $error("non-ip frame was mapped by ip dscp key");
  AST_CASCADE_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clm_vld_i && clm_lookup_i < crq_pkg::LAST_LOOKUP && clm_nxt_ctrl_i == crq_pkg::NX_LOAD
    |=> g_idx_o == $past(clm_nxt_idx_i))
    else $error("generic index not loaded from action");
  AST_CASCADE_END: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clm_vld_i && clm_lookup_i == crq_pkg::LAST_LOOKUP |=> g_idx_o == '0)
    else $error("generic index survived the last lookup");
  AST_ENTRY_READBACK: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_wr_i && reg_addr_i == crq_pkg::ENTRY_BASE ##1 reg_rd_i && reg_addr_i == crq_pkg::ENTRY_BASE
    |=> reg_rdata_o == 32'($past(reg_wdata_i, 2) & 32'h001fffff))
    else $error("map entry read back wrong");
  // vector, qos and index hold between their own requests; read data drop to zero without a read
  AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data stood without a read");
  AST_GIDX_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !clm_vld_i |=> $stable(g_idx_o))
    else $error("generic index moved without an action");
  AST_RES_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !frm_vld_i |=> $stable(range_match_vector_o) && $stable(new_qos_o))
    else $error("frame results moved without a frame");
endmodule // crq_range_qos_map

// >>> dv/crq_pipe_model.sv
/*
 * Model of the classifier pipeline beside the range and qos map block:
 * issues frame strobes and the six cascaded lookup actions.
 * Assumes the bench sets frame fields at the edge where frame() starts.
 */
`timescale 1ns/10ps
module crq_pipe_model (
  input wire logic clk_i,
  output logic frm_vld_o,
  output logic clm_vld_o,
  output logic [2:0] clm_lookup_o,
  output logic [1:0] clm_nxt_ctrl_o,
  output logic [11:0] clm_nxt_idx_o
);
  // ------------------------------------------------------------
  // idle state at time zero
  // ------------------------------------------------------------
  initial begin
    frm_vld_o = 1'b0;
    clm_vld_o = 1'b0;
    clm_lookup_o = 3'h7;
    clm_nxt_ctrl_o = 2'h3;
    clm_nxt_idx_o = 12'hfff;
  end

  // one frame strobe; caller stands just past a rising edge
  task automatic frame();
    frm_vld_o <= 1'b1;
    @(posedge clk_i);
    frm_vld_o <= 1'b0;
  endtask

  // one lookup action; fields are garbled once the strobe drops so a
  // design that samples them late sees junk, not a stale good value
  task automatic casc(input logic [2:0] lk, input logic [1:0] ct, input logic [11:0] ix);
    clm_vld_o <= 1'b1;
    clm_lookup_o <= lk;
    clm_nxt_ctrl_o <= ct;
    clm_nxt_idx_o <= ix;
    @(posedge clk_i);
    clm_vld_o <= 1'b0;
    clm_lookup_o <= ~lk;
    clm_nxt_ctrl_o <= ~ct;
    clm_nxt_idx_o <= ~ix;
  endtask
endmodule // crq_pipe_model

// >>> dv/crq_range_qos_map_tb_top.sv
/*
 * Self-checking bench for the range checker, cascade index and qos map
 * block: register tasks, frame and cascade sequences with expected values.
 * Assumes the pipeline model in crq_pipe_model and two ports in the design.
 */
`timescale 1ns/10ps
module crq_range_qos_map_tb_top;
  logic clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, frm_port_i = 1'b0;
  logic frm_tcpudp_i = 1'b0, frm_ip_i = 1'b0, frm_etag_i = 1'b1, map_ovr_vld_i = 1'b0, map_ovr_sel_i = 1'b1;
  logic frm_o_dei_i = 1'b1, frm_m_dei_i = 1'b0, frm_i_dei_i = 1'b1, port_dei_i = 1'b0, frm_e_dei_i = 1'b1;
  logic [2:0] frm_o_pcp_i = 3'h5, frm_m_pcp_i = 3'h2, frm_i_pcp_i = 3'h6, port_pcp_i = 3'h1;
  logic [2:0] frm_e_pcp_i = 3'h3, frm_mpls_tc_i = 3'h4, clm_lookup_i;
  logic [15:0] reg_addr_i = 16'h0, frm_sport_i = 16'h0, frm_dport_i = 16'h0, frm_etype_i = 16'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [1:0] frm_ntags_i = 2'h0, clm_nxt_ctrl_i;
  logic [11:0] frm_ovid_i = 12'h0, frm_ivid_i = 12'h0, cl_vid_i = 12'h0, clm_nxt_idx_i, g_idx_o;
  logic [5:0] frm_dscp_i = 6'h0;
  logic [crq_pkg::QV_W-1:0] cur_qos_i = 21'h0a5a5a, new_qos_o;
  logic [3:0] map_ovr_key_i = 4'h1;
  logic [8:0] map_ovr_base_i = 9'h014;
  logic [7:0] range_match_vector_o;
  logic frm_vld_i, clm_vld_i, res_vld_o;
  int fails = 0, checks_done = 0;
  localparam int OFF[8] = '{5, 13, 2, 14, 13, 13, 4, 11};
  localparam int CC[6] = '{1, 3, 2, 0, 1, 1};
  localparam int CI[6] = '{5, 3, 9, 9, 2047, 7};
  localparam int CE[6] = '{5, 8, 8, 0, 2047, 0};
  localparam int ROWS[4] = '{16, 17, 20, 25};

  crq_range_qos_map #(.NPORT(2)) uut (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .frm_vld_i, .frm_port_i, .frm_tcpudp_i, .frm_ip_i, .frm_sport_i, .frm_dport_i, .frm_etype_i,
    .frm_ntags_i, .frm_ovid_i, .frm_ivid_i, .frm_o_pcp_i, .frm_o_dei_i, .frm_m_pcp_i, .frm_m_dei_i, .frm_i_pcp_i,
    .frm_i_dei_i, .port_pcp_i, .port_dei_i, .frm_etag_i, .frm_e_pcp_i, .frm_e_dei_i, .frm_mpls_tc_i, .cl_vid_i,
    .frm_dscp_i, .cur_qos_i, .map_ovr_vld_i, .map_ovr_sel_i, .map_ovr_key_i, .map_ovr_base_i, .clm_vld_i,
    .clm_lookup_i, .clm_nxt_ctrl_i, .clm_nxt_idx_i, .res_vld_o, .range_match_vector_o, .new_qos_o, .g_idx_o);
  crq_pipe_model pm (.clk_i, .frm_vld_o(frm_vld_i), .clm_vld_o(clm_vld_i), .clm_lookup_o(clm_lookup_i),
    .clm_nxt_ctrl_o(clm_nxt_ctrl_i), .clm_nxt_idx_o(clm_nxt_idx_i));

  // 100 ns period
  always #50 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  // one frame with most fields equal to v; result one cycle later
  task automatic fr(input logic [15:0] v, dp, input logic t, ip, input logic [1:0] nt, input logic [7:0] ev);
    @(posedge clk_i);
    {frm_sport_i, frm_etype_i, frm_dport_i} <= {v, v, dp};
    {frm_ovid_i, frm_ivid_i, cl_vid_i} <= {3{v[11:0]}};
    frm_dscp_i <= v[5:0];
    {frm_tcpudp_i, frm_ip_i, frm_ntags_i} <= {t, ip, nt};
    pm.frame();
    #1 chk(32'(res_vld_o), 32'h1);
    chk(32'(range_match_vector_o), 32'(ev));
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog: the sequence needs a few hundred cycles at most
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 chk(32'({res_vld_o, range_match_vector_o, g_idx_o}), 32'h0);
    chk(32'(new_qos_o), 32'h0);
    // global checker n gets type n+1, range 10..20
    for (int n = 0; n < 8; n++) begin
      wr(crq_pkg::GRNG_TYPE_BASE + 16'(4 * n), 32'(n + 1));
      wr(crq_pkg::GRNG_BND_BASE + 16'(4 * n), 32'h0014000a);
    end
    rd(crq_pkg::GRNG_BND_BASE + 16'h4, 32'h0014000a);
    wr(16'h4000, 32'hffffffff);
    rd(16'h4000, 32'h0);
    // back-to-back write and read of entry 0
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= crq_pkg::ENTRY_BASE;
    reg_wdata_i <= 32'hffffffff;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, 32'h001fffff);
    fr(16'd15, 16'd15, 1'b1, 1'b1, 2'd2, 8'hff);
    fr(16'd10, 16'd10, 1'b1, 1'b1, 2'd2, 8'hff);
    fr(16'd20, 16'd20, 1'b1, 1'b1, 2'd2, 8'hff);
    fr(16'd21, 16'd21, 1'b1, 1'b1, 2'd2, 8'h00);
    fr(16'd9, 16'd9, 1'b1, 1'b1, 2'd2, 8'h00);
    fr(16'd15, 16'd15, 1'b0, 1'b0, 2'd0, 8'h28);
    fr(16'd15, 16'd15, 1'b0, 1'b1, 2'd1, 8'h78);
    fr(16'd15, 16'd99, 1'b1, 1'b1, 2'd2, 8'hfe);
    // port 1 checker 0: ethertype 0..5 decides bit 0 over the global one
    wr(crq_pkg::PRNG_BASE + crq_pkg::PRNG_STRIDE, 32'(crq_pkg::RT_ETYPE));
    wr(crq_pkg::PRNG_BASE + crq_pkg::PRNG_STRIDE + crq_pkg::PRNG_BND_OFS, 32'h00050000);
    frm_port_i <= 1'b1;
    fr(16'd15, 16'd15, 1'b1, 1'b1, 2'd2, 8'hfe);
    rd(crq_pkg::STATUS_ADDR, 32'h000000fe);
    frm_port_i <= 1'b0;
    fr(16'd15, 16'd15, 1'b1, 1'b1, 2'd2, 8'hff);
    // map rows 16, 17, 20 and 25 fully enabled; base row 16
    foreach (ROWS[i]) wr(crq_pkg::SETCTL_BASE + 16'(4 * ROWS[i]), 32'h7f);
    for (int k = 1; k < 9; k++) begin
      wr(crq_pkg::MAPCFG_BASE, 32'(k * 512 + 16));
      wr(crq_pkg::ENTRY_BASE + 16'(4 * (128 + OFF[k-1])), 32'(k * 273 + 4096));
      fr(16'd13, 16'd13, 1'b1, 1'b1, 2'd3, 8'hff);
      chk(32'(new_qos_o), 32'(k * 273 + 4096));
    end
    wr(crq_pkg::MAPCFG_BASE, 32'(5 * 512 + 16));
    fr(16'd13, 16'd13, 1'b0, 1'b0, 2'd3, 8'he8);
    chk(32'(new_qos_o), 32'(cur_qos_i));
    wr(crq_pkg::ENTRY_BASE + 16'(4 * 205), 32'h1abcd);
    wr(crq_pkg::MAPCFG_BASE, 32'(6 * 512 + 16));
    fr(16'd13, 16'd13, 1'b0, 1'b0, 2'd3, 8'he8);
    chk(32'(new_qos_o), 32'h1abcd);
    frm_etag_i <= 1'b0;
    wr(crq_pkg::MAPCFG_BASE, 32'(8 * 512 + 16));
    fr(16'd13, 16'd13, 1'b1, 1'b1, 2'd3, 8'hff);
    chk(32'(new_qos_o), 32'(cur_qos_i));
    // row 16 enables only tc; entry 133 still holds 21'h001111
    wr(crq_pkg::SETCTL_BASE + 16'h40, 32'h01);
    wr(crq_pkg::MAPCFG_BASE, 32'(1 * 512 + 16));
    fr(16'd13, 16'd13, 1'b1, 1'b1, 2'd3, 8'hff);
    chk(32'(new_qos_o), 32'({cur_qos_i[20:3], 3'h1}));
    // action overrides lookup 1: pcp key at row 20, applied last
    wr(crq_pkg::ENTRY_BASE + 16'(4 * 165), 32'h0f0f0);
    map_ovr_vld_i <= 1'b1;
    fr(16'd13, 16'd13, 1'b1, 1'b1, 2'd3, 8'hff);
    chk(32'(new_qos_o), 32'h0f0f0);
    map_ovr_vld_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      pm.casc(3'(i), 2'(CC[i]), 12'(CI[i]));
      #1 chk(32'(g_idx_o), 32'(CE[i]));
    end
    wrap_up();
  end
endmodule // crq_range_qos_map_tb_top
